// ==== rtl/rsh_pkg.sv ====
package rsh_pkg;

  // ==========================================================
  // Widths
  // ==========================================================
  localparam int DAC_W = 10;
  localparam int DIV_W = 10;
  localparam int SYNC_N = 5;

  // ==========================================================
  // Input select modes
  // ==========================================================
  localparam logic [2:0] MODE_MAN0 = 3'h0;
  localparam logic [2:0] MODE_MAN1 = 3'h1;
  localparam logic [2:0] MODE_MAN2 = 3'h2;
  localparam logic [2:0] MODE_PIN = 3'h3;
  localparam logic [2:0] MODE_AUTO = 3'h4;
  localparam logic [2:0] MODE_AUTO_PIN = 3'h6;

  // ==========================================================
  // Holdover enable field and field positions
  // ==========================================================
  localparam logic [1:0] HOLD_ENABLED = 2'h2;
  localparam logic [1:0] HOLD_DISABLED = 2'h0;
  localparam int SYN_PIN_A = 0;
  localparam int SYN_PIN_B = 1;
  localparam int SYN_LOCK1 = 2;
  localparam int SYN_LOCK2 = 3;
  localparam int SYN_WIN = 4;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [1:0] ACTIVE_RST = 2'h0;
  localparam logic [DAC_W-1:0] DAC_RST = 10'h000;
  localparam logic [DIV_W-1:0] DIV_RST = 10'h000;

  // ==========================================================
  // Status pin sources
  // ==========================================================
  typedef enum logic [2:0] {
    SRC_LOW = 3'b000,
    SRC_LOCK1 = 3'b001,
    SRC_LOCK2 = 3'b010,
    SRC_LOCK_BOTH = 3'b011,
    SRC_HOLDOVER = 3'b100,
    SRC_RAIL = 3'b101
  } rsh_pin_src_t;

  typedef enum logic {
    ST_RUN = 1'b0,
    ST_HOLD = 1'b1
  } rsh_state_t;

  typedef struct packed {
    logic dac_track_enable;
    logic dac_manual_select;
    logic [DAC_W-1:0] dac_manual_value;
    logic [DIV_W-1:0] dac_update_divider;
  } rsh_dac_cfg_t;

  typedef struct packed {
    logic rail_trip_enable;
    logic [DAC_W-1:0] rail_high_threshold;
    logic [DAC_W-1:0] rail_low_threshold;
  } rsh_rail_cfg_t;

endpackage

// ==== rtl/rsh_ref_switch_holdover_ctrl.sv ====
`timescale 1ns/1ps
// Summary of operation
// - Pin-select with holdover: hold, then switch
// - Mode 4: advance to next enabled input, wrapping
// - Mode 4 never chooses disabled inputs; mode 6 follows the pins
// - New auto mode keeps active input if locked
// - Mask gates lock-loss events in mode 4
// - Lock must return high between events
// - Rail trip enters holdover, then event
// - Mode 4 holdover: advance, exit, keep
// - Mode 4 no holdover: advance at once
// - Mode 6 picks input from select pins
// - Mode 6 takes pin input, holdover optional
// - Holdover: pump high-Z, fixed tuning voltage
// - Holdover only when field is 2; force
// - Fixed sub-mode when manual DAC selected
// - Tracking DAC updates per divided period
// - Entry conditions for lock loss, rail trip
// - Holdover status flags and loop2 lock kept
// - Pump value from manual or tracked DAC
// - Holdover status routable to status pins
// - Exit on frequency window or disable
// - Manual modes force the chosen input
module rsh_ref_switch_holdover_ctrl (
  input wire logic clk_i, // Loop1 phase detector domain clock
  input wire logic resetn_i, // Async reset, active low
  input wire logic [2:0] input_select_mode_i, // Selection mode
  input wire logic [2:0] input_enable_bits_i, // Per-input enables
  input wire logic lock_loss_trigger_mask_i, // Masks lock-loss event
  input wire logic [1:0] holdover_enable_field_i, // 2 enables holdover
  input wire logic holdover_force_i, // Forces holdover
  input wire rsh_pkg::rsh_dac_cfg_t dac_cfg_i, // DAC configuration
  input wire rsh_pkg::rsh_rail_cfg_t rail_cfg_i, // Rail trip setup
  input wire logic sel_pin_a_i, // Select pin A (async)
  input wire logic sel_pin_b_i, // Select pin B (async)
  input wire logic sel_pin_invert_i, // Inverts select pins
  input wire logic loop1_lock_raw_i, // Loop1 lock detector (async)
  input wire logic loop2_lock_raw_i, // Loop2 lock detector (async)
  input wire logic freq_window_ok_i, // Within ppm window (async)
  input wire logic pd_tick_i, // One pulse per loop1 PD period
  input wire logic [rsh_pkg::DAC_W-1:0] vtune_code_i, // Tuning voltage
  input wire rsh_pkg::rsh_pin_src_t holdover_pin_source_i, // Pin mux
  input wire rsh_pkg::rsh_pin_src_t lock_pin_source_i, // Pin mux
  output logic [1:0] active_input_o, // Active reference index
  output logic holdover_o, // Holdover status
  output logic loop1_lock_flag_o, // Loop1 lock flag
  output logic loop2_lock_flag_o, // Loop2 lock flag
  output logic pump_hiz_o, // Loop1 charge pump high-Z
  output logic [rsh_pkg::DAC_W-1:0] loop1_pump_output_o, // DAC drive
  output logic [rsh_pkg::DAC_W-1:0] dac_readback_o, // Tracked DAC
  output logic switch_event_o, // Accepted switch event pulse
  output logic holdover_pin_o, // Status pin
  output logic lock_pin_o // Status pin
);

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  logic [rsh_pkg::SYNC_N-1:0] async_in;
  logic [rsh_pkg::SYNC_N-1:0] sync_meta_reg;
  logic [rsh_pkg::SYNC_N-1:0] sync_reg;

  assign async_in = {freq_window_ok_i, loop2_lock_raw_i,
                     loop1_lock_raw_i, sel_pin_b_i, sel_pin_a_i};

  genvar gi;
  generate
    for (gi = 0; gi < rsh_pkg::SYNC_N; gi = gi + 1)
    begin : g_sync
      always_ff @(posedge clk_i or negedge resetn_i)
      begin
        if (!resetn_i)
        begin
          sync_meta_reg[gi] <= 1'b0;
          sync_reg[gi] <= 1'b0;
        end
        else
        begin
          sync_meta_reg[gi] <= async_in[gi];
          sync_reg[gi] <= sync_meta_reg[gi];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Pin decode
  // ==========================================================
  logic pin_a, pin_b, plain_pin_hold;
  logic [1:0] auto_pin_sel, plain_pin_sel;

  assign pin_a = sync_reg[rsh_pkg::SYN_PIN_A] ^ sel_pin_invert_i;
  assign pin_b = sync_reg[rsh_pkg::SYN_PIN_B] ^ sel_pin_invert_i;

  always_comb
  begin
    if (pin_a)
      auto_pin_sel = 2'h0;
    else if (pin_b)
      auto_pin_sel = 2'h1;
    else
      auto_pin_sel = 2'h2;
  end

  // Both pins high requests holdover in plain pin mode
  assign plain_pin_sel = {pin_b & ~pin_a, pin_a & ~pin_b};
  assign plain_pin_hold = pin_a & pin_b;

  // ==========================================================
  // Priority search over enabled inputs
  // ==========================================================
  function automatic logic [2:0] next_enabled(
    input logic [1:0] cur,
    input logic [2:0] en
  );
    logic [2:0] res;
    res = {1'b0, cur};
    for (int k = 2; k >= 0; k--)
    begin
      if (en[k] && (k > int'(cur)))
        res = {1'b1, 2'(k)};
    end
    if (!res[2])
    begin
      for (int k = 2; k >= 0; k--)
      begin
        if (en[k])
          res = {1'b1, 2'(k)};
      end
    end
    next_enabled = res;
  endfunction

  // ==========================================================
  // Event detection
  // ==========================================================
  rsh_pkg::rsh_state_t state_reg;
  logic in_hold, lock_eff, lock_eff_q, lock_fall, armed_reg;
  logic rail_cond, rail_q, rail_edge, win_q, exit_rise;
  logic [1:0] pins_q;
  logic pin_change, hold_ok, mode_auto, mode_apin, mode_pin;
  logic auto_ev, pin_ev, hold_enter, hold_exit, mode_new;
  logic [2:0] mode_q, nxt, first_en;

  assign in_hold = (state_reg == rsh_pkg::ST_HOLD);
  assign hold_ok = (holdover_enable_field_i == rsh_pkg::HOLD_ENABLED);
  assign mode_auto = (input_select_mode_i == rsh_pkg::MODE_AUTO);
  assign mode_apin = (input_select_mode_i == rsh_pkg::MODE_AUTO_PIN);
  assign mode_pin = (input_select_mode_i == rsh_pkg::MODE_PIN);
  assign mode_new = (input_select_mode_i != mode_q);

  // Lock flag drops in holdover so a rail trip yields an event
  assign lock_eff = sync_reg[rsh_pkg::SYN_LOCK1] & ~in_hold;
  assign lock_fall = lock_eff_q & ~lock_eff;

  assign rail_cond = rail_cfg_i.rail_trip_enable &
    ((vtune_code_i >= rail_cfg_i.rail_high_threshold) |
     (vtune_code_i <= rail_cfg_i.rail_low_threshold));
  assign rail_edge = rail_cond & ~rail_q;
  assign exit_rise = sync_reg[rsh_pkg::SYN_WIN] & ~win_q;
  assign pin_change = ({pin_b, pin_a} != pins_q) & mode_pin;

  // Mask gates events only in the priority mode; it gates lock-loss holdover entry in every mode but 6
  assign auto_ev = armed_reg & lock_fall &
    ((mode_auto & ~lock_loss_trigger_mask_i) | mode_apin);
  assign pin_ev = pin_change;

  assign hold_enter = ~in_hold & (holdover_force_i
    | (hold_ok & lock_fall & ~lock_loss_trigger_mask_i)
    | (hold_ok & auto_ev)
    | (hold_ok & pin_ev)
    | (hold_ok & rail_edge & dac_cfg_i.dac_track_enable
       & dac_cfg_i.dac_manual_select));

  // Force holds the state; disabling the field exits at once
  assign hold_exit = in_hold & ~holdover_force_i &
    (~hold_ok | (exit_rise & ~(mode_pin & plain_pin_hold)));

  assign nxt = next_enabled(active_input_o, input_enable_bits_i);
  assign first_en = next_enabled(2'h2, input_enable_bits_i);

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      lock_eff_q <= 1'b0;
      rail_q <= 1'b0;
      win_q <= 1'b0;
      pins_q <= 2'h0;
      mode_q <= rsh_pkg::MODE_MAN0;
    end
    else
    begin
      lock_eff_q <= lock_eff;
      rail_q <= rail_cond;
      win_q <= sync_reg[rsh_pkg::SYN_WIN];
      pins_q <= {pin_b, pin_a};
      mode_q <= input_select_mode_i;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      armed_reg <= 1'b1;
    else if (auto_ev)
      armed_reg <= 1'b0;
    else if (lock_eff)
      armed_reg <= 1'b1;
  end

  // ==========================================================
  // Holdover state
  // ==========================================================
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      state_reg <= rsh_pkg::ST_RUN;
    else
    begin
      unique case (state_reg)
        rsh_pkg::ST_RUN:
        begin
          if (hold_enter)
            state_reg <= rsh_pkg::ST_HOLD;
        end
        rsh_pkg::ST_HOLD:
        begin
          if (hold_exit)
            state_reg <= rsh_pkg::ST_RUN;
        end
      endcase
    end
  end

  // ==========================================================
  // Active input selection
  // ==========================================================
  logic [1:0] pend_reg;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      active_input_o <= rsh_pkg::ACTIVE_RST;
      pend_reg <= rsh_pkg::ACTIVE_RST;
    end
    else if (input_select_mode_i <= rsh_pkg::MODE_MAN2)
      active_input_o <= input_select_mode_i[1:0];
    else if (mode_new && (mode_auto || mode_apin))
    begin
      // Without lock there is nothing worth keeping
      if (!loop1_lock_flag_o && mode_auto && first_en[2])
        active_input_o <= first_en[1:0];
      else if (!loop1_lock_flag_o && mode_apin)
        active_input_o <= auto_pin_sel;
    end
    else if (auto_ev && mode_auto && nxt[2])
      active_input_o <= nxt[1:0];
    else if (auto_ev && mode_apin)
      active_input_o <= auto_pin_sel;
    else if (pin_ev && !plain_pin_hold)
    begin
      pend_reg <= plain_pin_sel;
      if (!hold_ok)
        active_input_o <= plain_pin_sel;
    end
    else if (mode_pin && hold_exit)
      active_input_o <= pend_reg;
  end

  // ==========================================================
  // Tracking DAC
  // ==========================================================
  logic [rsh_pkg::DIV_W-1:0] div_cnt_reg;
  logic dac_tick;
  logic fixed_mode;

  assign dac_tick = pd_tick_i &
    ((div_cnt_reg + 10'h001) >= dac_cfg_i.dac_update_divider);

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      div_cnt_reg <= rsh_pkg::DIV_RST;
    else if (!dac_cfg_i.dac_track_enable)
      div_cnt_reg <= rsh_pkg::DIV_RST;
    else if (dac_tick)
      div_cnt_reg <= rsh_pkg::DIV_RST;
    else if (pd_tick_i)
      div_cnt_reg <= div_cnt_reg + 10'h001;
  end

  // Tracked value freezes in holdover: last valid voltage
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      dac_readback_o <= rsh_pkg::DAC_RST;
    else if (dac_cfg_i.dac_track_enable && dac_tick && !in_hold)
      dac_readback_o <= vtune_code_i;
  end

  // Tracked sub-mode is not valid with rail trip, so fall to fixed
  assign fixed_mode = dac_cfg_i.dac_manual_select |
    ~dac_cfg_i.dac_track_enable |
    rail_cfg_i.rail_trip_enable;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      loop1_pump_output_o <= rsh_pkg::DAC_RST;
    else if (fixed_mode)
      loop1_pump_output_o <= dac_cfg_i.dac_manual_value;
    else
      loop1_pump_output_o <= dac_readback_o;
  end

  // ==========================================================
  // Status outputs
  // ==========================================================
  function automatic logic pin_mux(
    input rsh_pkg::rsh_pin_src_t src,
    input logic l1,
    input logic l2,
    input logic ho,
    input logic rail
  );
    unique case (src)
      rsh_pkg::SRC_LOW: pin_mux = 1'b0;
      rsh_pkg::SRC_LOCK1: pin_mux = l1;
      rsh_pkg::SRC_LOCK2: pin_mux = l2;
      rsh_pkg::SRC_LOCK_BOTH: pin_mux = l1 & l2;
      rsh_pkg::SRC_HOLDOVER: pin_mux = ho;
      rsh_pkg::SRC_RAIL: pin_mux = rail;
      default: pin_mux = 1'b0;
    endcase
  endfunction

  assign holdover_o = in_hold;
  assign pump_hiz_o = in_hold;
  assign loop1_lock_flag_o = lock_eff;
  assign loop2_lock_flag_o = sync_reg[rsh_pkg::SYN_LOCK2];
  assign switch_event_o = auto_ev | pin_ev;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      holdover_pin_o <= 1'b0;
      lock_pin_o <= 1'b0;
    end
    else
    begin
      holdover_pin_o <= pin_mux(holdover_pin_source_i, lock_eff,
        loop2_lock_flag_o, in_hold, rail_cond);
      lock_pin_o <= pin_mux(lock_pin_source_i, lock_eff,
        loop2_lock_flag_o, in_hold, rail_cond);
    end
  end

endmodule

// ==== tb/rsh_ctrl_asserts.sv ====
`timescale 1ns/1ps
module rsh_ctrl_asserts (
  input wire logic clk_i, // Clock
  input wire logic resetn_i, // Reset, active low
  input wire logic [2:0] input_select_mode_i, // Mode
  input wire logic lock_loss_trigger_mask_i, // Lock-loss mask
  input wire logic [1:0] holdover_enable_field_i, // Holdover field
  input wire logic holdover_force_i, // Force
  input wire logic [1:0] active_input_o, // Active input
  input wire logic holdover_o, // Holdover status
  input wire logic loop1_lock_flag_o, // Loop1 lock flag
  input wire logic pump_hiz_o, // Pump high-Z
  input wire logic switch_event_o // Event pulse
);
  // ==========================================================
  // Properties
  // ==========================================================
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  property p_hiz;
    pump_hiz_o == holdover_o;
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("pump high-Z differs from holdover");

  property p_lock_ho;
    holdover_o |-> !loop1_lock_flag_o;
  endproperty
  a_lock_ho: assert property (p_lock_ho)
    else $error("loop1 lock flag high in holdover");

  property p_evt_pulse;
    switch_event_o |=> !switch_event_o;
  endproperty
  a_evt_pulse: assert property (p_evt_pulse)
    else $error("switch event longer than one cycle");

  property p_evt_ho;
    switch_event_o && holdover_enable_field_i == rsh_pkg::HOLD_ENABLED
      |=> holdover_o;
  endproperty
  a_evt_ho: assert property (p_evt_ho)
    else $error("event with holdover enabled did not enter holdover");

  property p_noho;
    holdover_enable_field_i != rsh_pkg::HOLD_ENABLED && !holdover_force_i
      |=> !holdover_o;
  endproperty
  a_noho: assert property (p_noho)
    else $error("holdover while disabled and not forced");

  property p_force;
    holdover_force_i |=> holdover_o;
  endproperty
  a_force: assert property (p_force)
    else $error("forced holdover not entered");

  property p_manual;
    input_select_mode_i <= rsh_pkg::MODE_MAN2
      |=> {1'b0, active_input_o} == $past(input_select_mode_i);
  endproperty
  a_manual: assert property (p_manual)
    else $error("manual mode did not set active input");

  property p_mask;
    input_select_mode_i == rsh_pkg::MODE_AUTO && lock_loss_trigger_mask_i
      |-> !switch_event_o;
  endproperty
  a_mask: assert property (p_mask)
    else $error("masked lock loss raised an event");

  c_evt_ho: cover property (switch_event_o ##1 holdover_o);
  c_force: cover property (holdover_force_i ##1 holdover_o);
  c_exit: cover property ($fell(holdover_o));
endmodule

bind rsh_ref_switch_holdover_ctrl rsh_ctrl_asserts u_rsh_ctrl_asserts (
  .clk_i,
  .resetn_i,
  .input_select_mode_i,
  .lock_loss_trigger_mask_i,
  .holdover_enable_field_i,
  .holdover_force_i,
  .active_input_o,
  .holdover_o,
  .loop1_lock_flag_o,
  .pump_hiz_o,
  .switch_event_o
);

// ==== tb/rsh_host_model.sv ====
`timescale 1ns/1ps
module rsh_host_model #(
  parameter int PD_DIV = 4,
  parameter logic [9:0] VTUNE = 10'h155
) (
  input wire logic clk_i, // Clock
  input wire logic resetn_i, // Reset, active low
  output logic pd_tick_o, // One pulse per PD period
  output logic [rsh_pkg::DAC_W-1:0] vtune_code_o // Loop1 tuning code
);
  logic [3:0] cnt_reg;

  // Steady tuning code, so a tracked value is easy to predict
  assign vtune_code_o = VTUNE;
  assign pd_tick_o = (cnt_reg == 4'h0);

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      cnt_reg <= 4'h0;
    else if (cnt_reg == 4'(PD_DIV - 1))
      cnt_reg <= 4'h0;
    else
      cnt_reg <= cnt_reg + 4'h1;
  end
endmodule

// ==== tb/rsh_ref_switch_holdover_ctrl_test.sv ====
`timescale 1ns/1ps
module rsh_ref_switch_holdover_ctrl_test;
  localparam logic [9:0] VT = 10'h155;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [2:0] mode = 3'h0;
  logic [2:0] en = 3'h0;
  logic mask = 1'b0;
  logic [1:0] hfield = rsh_pkg::HOLD_ENABLED;
  logic force_ho = 1'b0;
  rsh_pkg::rsh_dac_cfg_t dcfg = '{1'b1, 1'b1, 10'h2a5, 10'h002};
  rsh_pkg::rsh_rail_cfg_t rcfg = '{1'b0, 10'h3f0, 10'h010};
  logic pin_a = 1'b0;
  logic pin_b = 1'b0;
  logic pin_inv = 1'b0;
  logic lock1 = 1'b1;
  logic win = 1'b0;
  logic tick;
  logic [9:0] vtune;
  logic [1:0] act;
  logic ho, lk1, lk2, hiz, evt, ho_pin, lk_pin;
  logic [9:0] pump, rdbk;
  logic [4:0] tbl [3] = '{5'b01001, 5'b00010, 5'b11110};
  int n_errors = 0;
  int compares = 0;

  always #2 clk_i = ~clk_i;

  rsh_host_model #(.PD_DIV(4), .VTUNE(VT)) u_rsh_host_model (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .pd_tick_o(tick),
    .vtune_code_o(vtune)
  );

  rsh_ref_switch_holdover_ctrl u_rsh_ref_switch_holdover_ctrl (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .input_select_mode_i(mode),
    .input_enable_bits_i(en),
    .lock_loss_trigger_mask_i(mask),
    .holdover_enable_field_i(hfield),
    .holdover_force_i(force_ho),
    .dac_cfg_i(dcfg),
    .rail_cfg_i(rcfg),
    .sel_pin_a_i(pin_a),
    .sel_pin_b_i(pin_b),
    .sel_pin_invert_i(pin_inv),
    .loop1_lock_raw_i(lock1),
    .loop2_lock_raw_i(1'b1),
    .freq_window_ok_i(win),
    .pd_tick_i(tick),
    .vtune_code_i(vtune),
    .holdover_pin_source_i(rsh_pkg::SRC_HOLDOVER),
    .lock_pin_source_i(rsh_pkg::SRC_LOCK2),
    .active_input_o(act),
    .holdover_o(ho),
    .loop1_lock_flag_o(lk1),
    .loop2_lock_flag_o(lk2),
    .pump_hiz_o(hiz),
    .loop1_pump_output_o(pump),
    .dac_readback_o(rdbk),
    .switch_event_o(evt),
    .holdover_pin_o(ho_pin),
    .lock_pin_o(lk_pin)
  );

  // ==========================================================
  // Shared tasks
  // ==========================================================
  task automatic results();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [9:0] e, logic [9:0] g);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Bounded look for the one-cycle event pulse
  task automatic wait_evt(output logic seen);
    seen = 1'b0;
    for (int i = 0; i < 10 && !seen; i++)
    begin
      @(negedge clk_i);
      seen = evt;
    end
  endtask

  // Lock on input 0 by hand before entering an automatic mode
  task automatic prep(input logic [2:0] md);
    @(posedge clk_i);
    mode <= rsh_pkg::MODE_MAN0;
    lock1 <= 1'b1;
    win <= 1'b0;
    repeat (6) @(posedge clk_i);
    mode <= md;
    repeat (3) @(negedge clk_i);
    chk("lock flag", 10'h1, 10'(lk1));
    chk("active kept", 10'h0, 10'(act));
  endtask

  task automatic sw_evt(input logic [1:0] ea, input logic eh);
    logic seen;
    @(posedge clk_i);
    lock1 <= 1'b0;
    wait_evt(seen);
    chk("event", 10'h1, 10'(seen));
    @(negedge clk_i);
    chk("active", 10'(ea), 10'(act));
    chk("holdover", 10'(eh), 10'(ho));
    chk("high-Z", 10'(eh), 10'(hiz));
    chk("lock1 flag", 10'h0, 10'(lk1));
    chk("lock2 flag", 10'h1, 10'(lk2));
    if (eh)
    begin
      @(negedge clk_i);
      chk("pump", dcfg.dac_manual_value, pump);
      chk("holdover pin", 10'h1, 10'(ho_pin));
      chk("lock pin", 10'h1, 10'(lk_pin));
      @(posedge clk_i);
      win <= 1'b1;
      repeat (5) @(negedge clk_i);
      chk("exit", 10'h0, 10'(ho));
      chk("kept", 10'(ea), 10'(act));
    end
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_manual();
    for (int m = 0; m < 3; m++)
    begin
      @(posedge clk_i);
      mode <= 3'(m);
      repeat (3) @(negedge clk_i);
      chk("manual active", 10'(m), 10'(act));
    end
  endtask

  task automatic t_mask();
    logic seen;
    prep(rsh_pkg::MODE_AUTO);
    @(posedge clk_i);
    mask <= 1'b1;
    lock1 <= 1'b0;
    wait_evt(seen);
    chk("masked event", 10'h0, 10'(seen));
    chk("masked active", 10'h0, 10'(act));
    @(posedge clk_i);
    mask <= 1'b0;
  endtask

  task automatic t_pins();
    hfield <= rsh_pkg::HOLD_ENABLED;
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk_i);
      {pin_a, pin_b, pin_inv} <= tbl[i][4:2];
      prep(rsh_pkg::MODE_AUTO_PIN);
      sw_evt(tbl[i][1:0], 1'b1);
    end
  endtask

  task automatic t_force();
    @(posedge clk_i);
    hfield <= rsh_pkg::HOLD_DISABLED;
    force_ho <= 1'b1;
    repeat (3) @(negedge clk_i);
    chk("forced", 10'h1, 10'(ho));
    @(posedge clk_i);
    force_ho <= 1'b0;
    repeat (2) @(negedge clk_i);
    chk("released", 10'h0, 10'(ho));
  endtask

  task automatic t_track();
    @(posedge clk_i);
    dcfg.dac_update_divider <= 10'h002;
    dcfg.dac_manual_select <= 1'b0;
    repeat (20) @(negedge clk_i);
    chk("readback", VT, rdbk);
    chk("tracked pump", VT, pump);
  endtask

  // Threshold pulled below the steady tuning code trips the rail
  task automatic t_rail();
    logic seen;
    @(posedge clk_i);
    hfield <= rsh_pkg::HOLD_ENABLED;
    prep(rsh_pkg::MODE_AUTO);
    @(posedge clk_i);
    dcfg.dac_manual_select <= 1'b1;
    rcfg <= '{1'b1, 10'h100, 10'h010};
    wait_evt(seen);
    chk("rail event", 10'h1, 10'(seen));
    @(negedge clk_i);
    chk("rail holdover", 10'h1, 10'(ho));
    chk("rail active", 10'h1, 10'(act));
    chk("rail pump", dcfg.dac_manual_value, pump);
    @(posedge clk_i);
    rcfg.rail_trip_enable <= 1'b0;
    hfield <= rsh_pkg::HOLD_DISABLED;
    repeat (2) @(negedge clk_i);
    chk("rail exit", 10'h0, 10'(ho));
  endtask

  // Pins settle in a manual mode first, so no stray edge is seen
  task automatic t_pinsel();
    logic seen;
    @(posedge clk_i);
    hfield <= rsh_pkg::HOLD_ENABLED;
    {pin_a, pin_b, pin_inv} <= 3'b000;
    win <= 1'b0;
    mode <= rsh_pkg::MODE_MAN0;
    repeat (4) @(posedge clk_i);
    mode <= rsh_pkg::MODE_PIN;
    repeat (4) @(posedge clk_i);
    pin_b <= 1'b1;
    wait_evt(seen);
    chk("pin event", 10'h1, 10'(seen));
    @(negedge clk_i);
    chk("pin holdover", 10'h1, 10'(ho));
    chk("pin pending", 10'h0, 10'(act));
    @(posedge clk_i);
    win <= 1'b1;
    repeat (5) @(negedge clk_i);
    chk("pin exit", 10'h0, 10'(ho));
    chk("pin switched", 10'h2, 10'(act));
  endtask

  initial
  begin
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(negedge clk_i);
    chk("reset active", 10'h0, 10'(act));
    chk("reset holdover", 10'h0, 10'(ho));
    t_manual();
    @(posedge clk_i);
    en <= 3'b101;
    prep(rsh_pkg::MODE_AUTO);
    sw_evt(2'h2, 1'b1);
    @(posedge clk_i);
    hfield <= rsh_pkg::HOLD_DISABLED;
    en <= 3'b111;
    prep(rsh_pkg::MODE_AUTO);
    sw_evt(2'h1, 1'b0);
    t_mask();
    t_pins();
    t_force();
    t_track();
    t_rail();
    t_pinsel();
    results();
  end

  // Whole run needs a few hundred cycles at most
  initial
  begin
    #40000;
    n_errors++;
    $display("ERROR watchdog expected finish seen timeout");
    results();
  end
endmodule
